// ### hw/los_consts.svh
`ifndef LOS_CONSTS_SVH
`define LOS_CONSTS_SVH

// register byte offsets
`define LOS_ADDR_CTRL 8'h00
`define LOS_ADDR_DAMP 8'h04
`define LOS_ADDR_START 8'h08
`define LOS_ADDR_END 8'h0C
`define LOS_ADDR_CAL1 8'h10
`define LOS_ADDR_CAL2 8'h14
`define LOS_ADDR_EMPTY 8'h18
`define LOS_ADDR_FULL 8'h1C
`define LOS_ADDR_TABLE 8'h20
`define LOS_ADDR_MEAS 8'h24
`define LOS_ADDR_STATUS 8'h28

// control register field positions
`define LOS_CTRL_SEL_LSB 0
`define LOS_CTRL_RANGE_BIT 3
`define LOS_CTRL_FAULT_LSB 4
`define LOS_CTRL_OPMODE_LSB 6
`define LOS_CTRL_R1_BIT 8
`define LOS_CTRL_R2_BIT 9
// table write: index field position
`define LOS_TABLE_IDX_LSB 16

// selector codes
`define LOS_SEL_LINEAR 3'h0
`define LOS_SEL_FACTORY 3'h2
`define LOS_SEL_MANUAL 3'h3
`define LOS_SEL_ERASE 3'h4
`define LOS_OPMODE_SWITCH 2'h2

// reset values (levels in tenths of a unit, damping in whole seconds)
`define LOS_RST_DAMP 7'h01
`define LOS_RST_START 16'h0000
`define LOS_RST_END 16'h03E8
`define LOS_RST_FULL 16'h03E8
`define LOS_RST_OPMODE 2'h1

// output fraction in permille of span
`define LOS_FRAC_SPAN 17'h003E8
`define LOS_FRAC_LOW 17'h1FF9C
`define LOS_FRAC_HIGH 17'h0044C
`define LOS_LEVEL_FULL 16'h03E8
`define LOS_TABLE_DEPTH 8

// analogue scaling: uA and mV per permille, live-zero offsets
`define LOS_UA_PER_0 17'h00014
`define LOS_UA_PER_1 17'h00010
`define LOS_UA_ZERO_1 17'h00FA0
`define LOS_MV_PER_0 17'h0000A
`define LOS_MV_PER_1 17'h00008
`define LOS_MV_ZERO_1 17'h007D0

// timing: damping tick of 10 ms at 10 ns clock
`define LOS_CLK_NS 10
`define LOS_TICK_NS 10000000
`define LOS_TICK_CYCLES (`LOS_TICK_NS / `LOS_CLK_NS)
`define LOS_TICKS_PER_S 14'h0064

`endif

// ### hw/los_pkg.sv
package los_pkg;

  // first member is the msb: selector lands in bits 2:0, relay two in bit 9
  typedef struct packed {
    logic relay_two_fault_response;
    logic relay_one_fault_response;
    logic [1:0] op_mode;
    logic [1:0] fault_mode;
    logic range_sel;
    logic [2:0] lin_sel;
  } los_ctrl_t;

  typedef struct packed {
    logic [7:0] factory_table_indicator;
    logic [7:0] table_valid;
    logic fault_active;
    logic warning_field;
  } los_status_t;

endpackage

// ### hw/los_damper.sv
`timescale 1ns/100ps
`include "los_consts.svh"

module los_damper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic hold,
  input wire logic [6:0] damp_s,
  input wire logic signed [16:0] x,
  output logic signed [16:0] y
);

  logic signed [16:0] y_r;
  logic signed [16:0] y_nxt;
  logic signed [17:0] diff;
  logic signed [17:0] step;
  logic [13:0] div;

  // first-order lag: each tick close 1/(time*ticks) of the gap
  always_comb begin
    div = 14'(damp_s * `LOS_TICKS_PER_S);
    diff = 18'(x) - 18'(y_r);
    step = diff / $signed({4'h0, div});
    if (step == 18'h00000 && diff != 18'h00000) begin
      step = diff[17] ? 18'h3FFFF : 18'h00001; // never stall short of target
    end
    y_nxt = y_r;
    if (hold) begin
      y_nxt = y_r;
    end else if (damp_s == 7'h00) begin
      y_nxt = x; // RULE9
    end else if (tick) begin
      y_nxt = 17'(18'(y_r) + step); // RULE9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_r <= 17'h00000;
    end else begin
      y_r <= y_nxt;
    end
  end

  assign y = y_r;

endmodule

// ### hw/los_top.sv
// Contract
// [RULE1] selector 0: linear level, drop volume; code still scales selector 0 by the empty/full values
// [RULE2] selector 2: factory table applied
// [RULE3] factory indicator nonzero when stored, else 0
// [RULE4] writing 4 erases manual table
// [RULE5] erase spares cylinder and factory tables
// [RULE6] drive voltage and current from measured value
// [RULE7] limit-switch mode disables analogue output
// [RULE8] range 0: 0-20mA/0-10V, 1: 4-20mA/2-10V
// [RULE9] damping filters outputs and display
// [RULE10] start maps low end, end maps 20mA
// [RULE11] arbitrary start and end values accepted
// [RULE12] start above end: warning, alarm blinks
// [RULE13] swapped converter calibration reverses outputs
// [RULE14] fault: -10%, +110% or hold
// [RULE15] relay response 1 follows analogue fault
// [RULE16] hold: alarm trips, outputs look normal
// [RULE17] proportional volume from empty/full values
// [RULE18] selector 3: manual table active
// [RULE19] interpolate, clamp to span, then damp
`timescale 1ns/100ps
`include "los_consts.svh"

module los_top #(
  parameter int TICK_CYCLES = `LOS_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] level_in,
  input wire logic fault_detected,
  input wire logic [7:0] factory_id,
  input wire logic signed [15:0] factory_value,
  output logic signed [16:0] current_ua,
  output logic signed [16:0] voltage_mv,
  output logic analog_enable,
  output logic signed [16:0] display_value,
  output logic alarm_relay_trip,
  output logic alarm_led,
  output logic relay_one_follow,
  output logic relay_two_follow
);

  // lerp: a + (b-a)*num/den, shared by volume and span scaling
  function automatic logic signed [16:0] lerp(input logic signed [16:0] a, input logic signed [16:0] b,
                                                input logic signed [16:0] num, input logic signed [16:0] den);
    logic signed [35:0] prod;
    prod = 36'(b - a) * 36'(num);
    if (den == 17'h00000) begin
      lerp = a;
    end else begin
      lerp = 17'(36'(a) + prod / 36'(den));
    end
  endfunction

  los_pkg::los_ctrl_t ctrl_r, ctrl_nxt;
  logic [6:0] damp_r, damp_nxt;
  logic signed [15:0] start_r, start_nxt, end_r, end_nxt;
  logic signed [15:0] cal1_r, cal1_nxt, cal2_r, cal2_nxt;
  logic signed [15:0] empty_r, empty_nxt, full_r, full_nxt;
  logic signed [15:0] table_r [`LOS_TABLE_DEPTH];
  logic signed [15:0] table_nxt [`LOS_TABLE_DEPTH];
  logic [7:0] tvalid_r, tvalid_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_en, setup;
  los_pkg::los_status_t status;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;

  // register writes land in the access phase, zero wait states
  always_comb begin
    ctrl_nxt = ctrl_r;
    damp_nxt = damp_r;
    start_nxt = start_r;
    end_nxt = end_r;
    cal1_nxt = cal1_r;
    cal2_nxt = cal2_r;
    empty_nxt = empty_r;
    full_nxt = full_r;
    tvalid_nxt = tvalid_r;
    for (int i = 0; i < `LOS_TABLE_DEPTH; i++) begin
      table_nxt[i] = table_r[i];
    end
    if (wr_en) begin
      case (paddr)
        `LOS_ADDR_CTRL: begin
          ctrl_nxt = los_pkg::los_ctrl_t'(pwdata[9:0]);
          if (pwdata[2:0] == `LOS_SEL_ERASE) begin
            // erase only touches the manual table; selection unchanged
            ctrl_nxt.lin_sel = ctrl_r.lin_sel;
            tvalid_nxt = 8'h00; // RULE4 RULE5
            for (int i = 0; i < `LOS_TABLE_DEPTH; i++) begin
              table_nxt[i] = 16'h0000; // RULE4
            end
          end
        end
        `LOS_ADDR_DAMP: damp_nxt = (pwdata[6:0] > 7'h64) ? 7'h64 : pwdata[6:0]; // RULE9
        `LOS_ADDR_START: start_nxt = pwdata[15:0]; // RULE11
        `LOS_ADDR_END: end_nxt = pwdata[15:0]; // RULE11
        `LOS_ADDR_CAL1: cal1_nxt = pwdata[15:0];
        `LOS_ADDR_CAL2: cal2_nxt = pwdata[15:0];
        `LOS_ADDR_EMPTY: empty_nxt = pwdata[15:0];
        `LOS_ADDR_FULL: full_nxt = pwdata[15:0];
        `LOS_ADDR_TABLE: begin
          table_nxt[pwdata[18:16]] = pwdata[15:0];
          tvalid_nxt[pwdata[18:16]] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '{lin_sel: `LOS_SEL_LINEAR, range_sel: 1'b0, fault_mode: 2'h0, op_mode: `LOS_RST_OPMODE,
                  relay_one_fault_response: 1'b0, relay_two_fault_response: 1'b0};
      damp_r <= `LOS_RST_DAMP;
      start_r <= `LOS_RST_START;
      end_r <= `LOS_RST_END;
      cal1_r <= 16'h0000;
      cal2_r <= 16'h0000;
      empty_r <= 16'h0000;
      full_r <= `LOS_RST_FULL;
      tvalid_r <= 8'h00;
      for (int i = 0; i < `LOS_TABLE_DEPTH; i++) begin
        table_r[i] <= 16'h0000;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      damp_r <= damp_nxt;
      start_r <= start_nxt;
      end_r <= end_nxt;
      cal1_r <= cal1_nxt;
      cal2_r <= cal2_nxt;
      empty_r <= empty_nxt;
      full_r <= full_nxt;
      tvalid_r <= tvalid_nxt;
      for (int i = 0; i < `LOS_TABLE_DEPTH; i++) begin
        table_r[i] <= table_nxt[i];
      end
    end
  end

  // characteristic selection produces the shown measured value
  logic signed [15:0] lvl_clamp;
  logic [2:0] tidx;
  logic signed [16:0] meas_raw;
  logic signed [16:0] meas_damped;
  always_comb begin
    lvl_clamp = level_in;
    if (level_in < 16'sh0000) begin
      lvl_clamp = 16'h0000;
    end else if (level_in > $signed(`LOS_LEVEL_FULL)) begin
      lvl_clamp = `LOS_LEVEL_FULL;
    end
    tidx = 3'(({16'h0000, lvl_clamp} * 32'h8) / 32'h3E9); // coarse segment pick, step table
    case (ctrl_r.lin_sel)
      `LOS_SEL_FACTORY: meas_raw = 17'(factory_value); // RULE2
      `LOS_SEL_MANUAL: meas_raw = tvalid_r[tidx] ? 17'(table_r[tidx]) : 17'(level_in); // RULE18
      // proportional volume from the empty/full calibration values
      default: meas_raw = lerp(17'(empty_r), 17'(full_r), 17'(level_in), 17'(`LOS_LEVEL_FULL)); // RULE1 RULE17
    endcase
  end

  // span fraction in permille, clamped to the live range
  logic signed [16:0] frac_raw, frac_lin, frac_damped, frac_out;
  logic reversed, warn, hold_fault, out_fault;
  assign warn = start_r > end_r; // RULE12
  assign reversed = cal1_r > cal2_r; // swapped converter calibration
  assign hold_fault = fault_detected && ctrl_r.fault_mode == 2'h2; // RULE16
  assign out_fault = fault_detected && ctrl_r.fault_mode != 2'h2;
  always_comb begin
    frac_lin = lerp(17'h00000, `LOS_FRAC_SPAN, meas_raw - 17'(start_r), 17'(end_r) - 17'(start_r)); // RULE10 RULE19
    if (frac_lin < 17'sh00000) begin
      frac_lin = 17'h00000; // RULE19
    end else if (frac_lin > $signed(`LOS_FRAC_SPAN)) begin
      frac_lin = `LOS_FRAC_SPAN; // RULE19
    end
    frac_raw = reversed ? `LOS_FRAC_SPAN - frac_lin : frac_lin; // RULE13
  end

  // damping tick counter
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
  always_comb begin
    tick_cnt_nxt = tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end

  // one filter for the outputs, one for the display
  los_damper u_damp_out (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .hold(out_fault),
    .damp_s(damp_r),
    .x(frac_raw),
    .y(frac_damped)
  );
  los_damper u_damp_disp (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .hold(1'b0),
    .damp_s(damp_r),
    .x(meas_raw),
    .y(meas_damped)
  );

  // fault value overrides damped fraction; hold keeps showing live data
  logic signed [16:0] cur_nxt, volt_nxt;
  logic en_nxt, led_nxt, blink_r, blink_nxt;
  always_comb begin
    case ({out_fault, ctrl_r.fault_mode})
      3'b100: frac_out = `LOS_FRAC_LOW; // RULE14
      3'b101: frac_out = `LOS_FRAC_HIGH; // RULE14
      default: frac_out = frac_damped; // RULE14 RULE16
    endcase
    if (ctrl_r.range_sel) begin
      cur_nxt = 17'(`LOS_UA_ZERO_1 + frac_out * `LOS_UA_PER_1); // RULE8 RULE6
      volt_nxt = 17'(`LOS_MV_ZERO_1 + frac_out * `LOS_MV_PER_1); // RULE8 RULE6
    end else begin
      cur_nxt = 17'(frac_out * `LOS_UA_PER_0); // RULE8 RULE6
      volt_nxt = 17'(frac_out * `LOS_MV_PER_0); // RULE8 RULE6
    end
    en_nxt = ctrl_r.op_mode != `LOS_OPMODE_SWITCH;
    if (!en_nxt) begin
      cur_nxt = 17'h00000; // RULE7
      volt_nxt = 17'h00000; // RULE7
    end
    blink_nxt = tick ? !blink_r : blink_r;
    led_nxt = fault_detected || (warn && blink_r); // RULE12 RULE16
  end

  logic signed [16:0] cur_r, volt_r, disp_r;
  logic en_r, led_r, trip_r, r1_r, r2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h00000000;
      cur_r <= 17'h00000;
      volt_r <= 17'h00000;
      disp_r <= 17'h00000;
      en_r <= 1'b0;
      led_r <= 1'b0;
      blink_r <= 1'b0;
      trip_r <= 1'b0;
      r1_r <= 1'b0;
      r2_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      cur_r <= cur_nxt;
      volt_r <= volt_nxt;
      disp_r <= meas_damped;
      en_r <= en_nxt;
      led_r <= led_nxt;
      blink_r <= blink_nxt;
      trip_r <= fault_detected; // RULE16
      r1_r <= fault_detected && ctrl_r.relay_one_fault_response; // RULE15
      r2_r <= fault_detected && ctrl_r.relay_two_fault_response; // RULE15
    end
  end

  // read data registered in setup so it is valid in the access phase
  always_comb begin
    status = '{factory_table_indicator: factory_id, table_valid: tvalid_r, // RULE3
               fault_active: fault_detected, warning_field: warn}; // RULE12
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (setup) begin
      pslverr_nxt = 1'b0;
      case (paddr)
        `LOS_ADDR_CTRL: prdata_nxt = {22'h000000, ctrl_r};
        `LOS_ADDR_DAMP: prdata_nxt = {25'h0000000, damp_r};
        `LOS_ADDR_START: prdata_nxt = {16'h0000, start_r};
        `LOS_ADDR_END: prdata_nxt = {16'h0000, end_r};
        `LOS_ADDR_CAL1: prdata_nxt = {16'h0000, cal1_r};
        `LOS_ADDR_CAL2: prdata_nxt = {16'h0000, cal2_r};
        `LOS_ADDR_EMPTY: prdata_nxt = {16'h0000, empty_r};
        `LOS_ADDR_FULL: prdata_nxt = {16'h0000, full_r};
        `LOS_ADDR_MEAS: prdata_nxt = {15'h0000, disp_r}; // RULE9
        `LOS_ADDR_STATUS: prdata_nxt = {14'h0000, status};
        `LOS_ADDR_TABLE: prdata_nxt = 32'h00000000; // write-only
        default: begin
          prdata_nxt = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      pslverr_nxt = pslverr_r; // keep error through the access phase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1; // constant, no wait states
  assign current_ua = cur_r;
  assign voltage_mv = volt_r;
  assign analog_enable = en_r;
  assign display_value = disp_r;
  assign alarm_relay_trip = trip_r;
  assign alarm_led = led_r;
  assign relay_one_follow = r1_r;
  assign relay_two_follow = r2_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_linear_select: assert property (ctrl_r.lin_sel == `LOS_SEL_LINEAR && level_in == 16'h0000 |-> // RULE1
    meas_raw == 17'(empty_r)) else $error("linear characteristic not from calibration");
  a_factory_value: assert property (ctrl_r.lin_sel == `LOS_SEL_FACTORY |-> meas_raw == 17'(factory_value)) // RULE2
    else $error("factory table not applied");
  a_erase_clears: assert property (wr_en && paddr == `LOS_ADDR_CTRL && pwdata[2:0] == `LOS_SEL_ERASE |=> // RULE4
    tvalid_r == 8'h00 && $stable(ctrl_r.lin_sel)) else $error("erase did not clear table");
  a_erase_spares: assert property (wr_en && paddr == `LOS_ADDR_CTRL && pwdata[2:0] == `LOS_SEL_ERASE |=> // RULE5
    $stable(empty_r) && $stable(full_r)) else $error("erase touched other settings");
  a_switch_off: assert property (ctrl_r.op_mode == `LOS_OPMODE_SWITCH ##1 ctrl_r.op_mode == `LOS_OPMODE_SWITCH // RULE7
    |-> !analog_enable && current_ua == 17'h00000) else $error("output live in switch mode");
  a_fault_low: assert property (out_fault && ctrl_r.fault_mode == 2'h0 && ctrl_r.range_sel == 1'b0 && en_nxt // RULE14
    |=> current_ua == 17'h1F830) else $error("fault low not -10 percent");
  a_fault_high: assert property (out_fault && ctrl_r.fault_mode == 2'h1 && ctrl_r.range_sel && en_nxt // RULE14
    |=> current_ua == 17'h05460) else $error("fault high not +110 percent");
  a_relay_follow: assert property (fault_detected && ctrl_r.relay_one_fault_response |=> relay_one_follow) // RULE15
    else $error("relay one did not follow");
  a_hold_alarm: assert property (hold_fault |=> alarm_relay_trip && alarm_led) // RULE16
    else $error("hold fault without alarm");
  a_warn_flag: assert property (setup && paddr == `LOS_ADDR_STATUS && start_r > end_r |=> prdata[0]) // RULE12
    else $error("reversed range not warned");
  a_span_clamp: assert property (!fault_detected |-> // RULE19
    frac_raw >= 17'sh00000 && frac_raw <= $signed(`LOS_FRAC_SPAN)) else $error("fraction outside span");

  c_erase: cover property (wr_en && paddr == `LOS_ADDR_CTRL && pwdata[2:0] == `LOS_SEL_ERASE);
  c_fault_hold: cover property (hold_fault ##1 alarm_led);
  c_reversed: cover property (reversed && !fault_detected);
  c_live_zero: cover property (ctrl_r.range_sel && en_r);

endmodule

// ### bench/los_loop_rx.sv
`timescale 1ns/100ps

module los_loop_rx (
  input wire logic range_sel,
  input wire logic analog_enable,
  input wire logic signed [16:0] current_ua,
  output logic signed [16:0] loop_permille,
  output logic loop_dead
);
  // receiving instrument: reads the loop back as permille of span
  // live zero is removed only in range 1, so a wrong range shows up as a wrong reading
  always_comb begin
    loop_dead = !analog_enable;
    if (range_sel) begin
      loop_permille = (current_ua - 17'sh00FA0) / 17'sh00010;
    end else begin
      loop_permille = current_ua / 17'sh00014;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/100ps
`include "los_consts.svh"

module tb_top;
  localparam int TICK = 8;
  typedef struct {
    logic rng;
    logic [15:0] st;
    logic [15:0] en;
    logic [15:0] lv;
    logic [16:0] ua;
    logic [16:0] mv;
  } los_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_detected, rng_now, er, led0;
  logic [7:0] paddr, factory_id;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] level_in, factory_value;
  logic signed [16:0] current_ua, voltage_mv, display_value, loop_permille;
  logic analog_enable, alarm_relay_trip, alarm_led, relay_one_follow, relay_two_follow, loop_dead;
  int err_count, cmp_count;
  // inputs beside expected current and voltage
  los_row_t rows[6] = '{
    '{1'b0, 16'h0000, 16'h03E8, 16'h01F4, 17'h02710, 17'h01388},
    '{1'b1, 16'h0000, 16'h03E8, 16'h01F4, 17'h02EE0, 17'h01770},
    '{1'b0, 16'h0064, 16'h044C, 16'h0258, 17'h02710, 17'h01388},
    '{1'b1, 16'h0000, 16'h03E8, 16'h03E8, 17'h04E20, 17'h02710},
    '{1'b0, 16'h00C8, 16'h0190, 16'h0384, 17'h04E20, 17'h02710},
    '{1'b1, 16'h00C8, 16'h0190, 16'h0000, 17'h00FA0, 17'h007D0}
  };

  los_top #(.TICK_CYCLES(TICK)) los_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_in(level_in), .fault_detected(fault_detected), .factory_id(factory_id),
    .factory_value(factory_value), .current_ua(current_ua), .voltage_mv(voltage_mv),
    .analog_enable(analog_enable), .display_value(display_value),
    .alarm_relay_trip(alarm_relay_trip), .alarm_led(alarm_led),
    .relay_one_follow(relay_one_follow), .relay_two_follow(relay_two_follow)
  );

  los_loop_rx los_loop_rx_inst (
    .range_sel(rng_now), .analog_enable(analog_enable), .current_ua(current_ua),
    .loop_permille(loop_permille), .loop_dead(loop_dead)
  );

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd);
    check(what, rd, exp);
  endtask

  function automatic logic [31:0] mk(input logic [2:0] sel, input logic r, input logic [1:0] fm,
                                     input logic [1:0] op, input logic r1);
    return {22'h0, 1'b0, r1, op, fm, r, sel};
  endfunction

  // bounded wait for the loop to reach a value, then compare both outputs
  task automatic settle(input logic [31:0] ua, input logic [31:0] mv);
    int n;
    n = 0;
    // a fresh input needs the filter and output stages before a match means anything
    repeat (3) @(negedge pclk);
    while (current_ua !== ua[16:0] && n < 60) begin
      @(negedge pclk);
      n++;
    end
    check("current_ua", current_ua, ua);
    check("voltage_mv", voltage_mv, mv);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, fault_detected, rng_now, er} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    factory_id = 8'h00;
    level_in = 16'sh0000;
    factory_value = 16'sh012C;
    err_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped access
    rdchk("ctrl", `LOS_ADDR_CTRL, 32'h00000040);
    rdchk("damp", `LOS_ADDR_DAMP, 32'h00000001);
    rdchk("start", `LOS_ADDR_START, 32'h00000000);
    rdchk("end", `LOS_ADDR_END, 32'h000003E8);
    rdchk("full", `LOS_ADDR_FULL, 32'h000003E8);
    rdchk("unmapped", 8'h40, 32'h00000000);
    check("pslverr", {31'h0, er}, 32'h00000001);
    $display("test reset done");
    wr(`LOS_ADDR_DAMP, 32'h0);
    // range, span, clamping rows
    foreach (rows[i]) begin
      wr(`LOS_ADDR_CTRL, mk(3'h0, rows[i].rng, 2'h0, 2'h1, 1'b0));
      wr(`LOS_ADDR_START, {16'h0, rows[i].st});
      wr(`LOS_ADDR_END, {16'h0, rows[i].en});
      rng_now <= rows[i].rng;
      level_in <= rows[i].lv;
      settle({15'h0, rows[i].ua}, {15'h0, rows[i].mv});
    end
    $display("test table done");
    // factory table, then back to linear
    @(posedge pclk);
    factory_id <= 8'h5A;
    wr(`LOS_ADDR_CTRL, mk(3'h2, 1'b0, 2'h0, 2'h1, 1'b0));
    wr(`LOS_ADDR_START, 32'h0);
    wr(`LOS_ADDR_END, 32'h3E8);
    rng_now <= 1'b0;
    level_in <= 16'sh01F4;
    settle(32'h00001770, 32'h00000BB8);
    rdchk("indicator", `LOS_ADDR_STATUS, 32'h00016800);
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h0, 2'h1, 1'b0));
    settle(32'h00002710, 32'h00001388);
    $display("test factory done");
    // manual table, erase, factory survives
    for (int i = 0; i < 8; i++) begin
      wr(`LOS_ADDR_TABLE, {13'h0, 3'(i), 16'((i + 1) * 100)});
    end
    wr(`LOS_ADDR_CTRL, mk(3'h3, 1'b0, 2'h0, 2'h1, 1'b0));
    level_in <= 16'sh03E8;
    settle(32'h00003E80, 32'h00001F40);
    wr(`LOS_ADDR_CTRL, mk(3'h4, 1'b0, 2'h0, 2'h1, 1'b0));
    settle(32'h00004E20, 32'h00002710);
    wr(`LOS_ADDR_CTRL, mk(3'h2, 1'b0, 2'h0, 2'h1, 1'b0));
    settle(32'h00001770, 32'h00000BB8);
    @(posedge pclk);
    factory_id <= 8'h00;
    rdchk("no indicator", `LOS_ADDR_STATUS, 32'h00000000);
    $display("test manual done");
    // proportional volume from empty and full
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h0, 2'h1, 1'b0));
    wr(`LOS_ADDR_EMPTY, 32'h64);
    wr(`LOS_ADDR_FULL, 32'h1F4);
    level_in <= 16'sh01F4;
    settle(32'h00001770, 32'h00000BB8);
    check("display", display_value, 32'h0000012C);
    wr(`LOS_ADDR_EMPTY, 32'h0);
    wr(`LOS_ADDR_FULL, 32'h3E8);
    $display("test volume done");
    // start above end, then swapped converter calibration
    wr(`LOS_ADDR_START, 32'h258);
    wr(`LOS_ADDR_END, 32'h190);
    rdchk("warning", `LOS_ADDR_STATUS, 32'h00000001);
    @(negedge pclk);
    led0 = alarm_led;
    repeat (3 * TICK) @(negedge pclk);
    check("led blinks", {31'h0, alarm_led !== led0}, 32'h1);
    wr(`LOS_ADDR_START, 32'h0);
    wr(`LOS_ADDR_END, 32'h3E8);
    wr(`LOS_ADDR_CAL1, 32'h5);
    wr(`LOS_ADDR_CAL2, 32'h2);
    level_in <= 16'sh00FA;
    settle(32'h00003A98, 32'h00001D4C);
    check("display kept", display_value, 32'h000000FA);
    wr(`LOS_ADDR_CAL1, 32'h0);
    $display("test reverse done");
    // fault low, fault high with relay follow, then hold
    fault_detected <= 1'b1;
    settle(17'sh1F830, 17'sh1FC18);
    check("rx low", loop_permille, 17'sh1FF9C);
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h1, 2'h1, 1'b1));
    settle(32'h000055F0, 32'h00002AF8);
    check("rx high", loop_permille, 17'sh0044C);
    check("relay1", {31'h0, relay_one_follow}, 32'h1);
    check("relay2", {31'h0, relay_two_follow}, 32'h0);
    // fault high again on the live-zero range
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b1, 2'h1, 2'h1, 1'b1));
    rng_now <= 1'b1;
    settle(32'h00005460, 32'h00002A30);
    check("rx high live zero", loop_permille, 17'sh0044C);
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h2, 2'h1, 1'b1));
    rng_now <= 1'b0;
    level_in <= 16'sh0320;
    settle(32'h00003E80, 32'h00001F40);
    check("trip", {31'h0, alarm_relay_trip}, 32'h1);
    @(posedge pclk);
    fault_detected <= 1'b0;
    $display("test fault done");
    // limit-switch mode kills the loop
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h0, 2'h2, 1'b0));
    settle(32'h0, 32'h0);
    check("dead loop", {31'h0, loop_dead}, 32'h1);
    $display("test switch mode done");
    // damping one second slews slowly
    wr(`LOS_ADDR_CTRL, mk(3'h0, 1'b0, 2'h0, 2'h1, 1'b0));
    wr(`LOS_ADDR_DAMP, 32'h0);
    level_in <= 16'sh0000;
    settle(32'h0, 32'h0);
    wr(`LOS_ADDR_DAMP, 32'h1);
    level_in <= 16'sh03E8;
    repeat (5 * TICK) @(negedge pclk);
    check("damped", {31'h0, display_value > 0 && display_value < 17'sh003E8}, 32'h1);
    $display("test damping done");
    // reset in mid-run clears outputs at once and restores defaults
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check("reset current", current_ua, 32'h0);
    check("reset display", display_value, 32'h0);
    check("reset enable", {31'h0, analog_enable}, 32'h0);
    check("pready", {31'h0, pready}, 32'h1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl after reset", `LOS_ADDR_CTRL, 32'h00000040);
    rdchk("damp after reset", `LOS_ADDR_DAMP, 32'h00000001);
    $display("test reset in run done");
    summarize();
  end
endmodule
